// ### drrc_pkg.sv
package drrc_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 100;
    localparam int unsigned SWAP_SAMPLE_MS     = 1;
    localparam int unsigned READY_DELAY_MS     = 3;
    localparam int unsigned MIN_RESET_LOW_US   = 10;
    localparam int unsigned SWAP_HOLD_MS       = 3;
    localparam int unsigned SWAP_SAMPLE_CYC    = SWAP_SAMPLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned READY_DELAY_CYC    = READY_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned MIN_RESET_LOW_CYC  = (MIN_RESET_LOW_US * 1000 + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS;
    localparam int unsigned SWAP_HOLD_CYC      = SWAP_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned CNT_W              = 16;
    // Role codes: idle, host repeater, device repeater.
    typedef enum logic [1:0] {
        DRRC_ROLE_NONE   = 2'h0,
        DRRC_ROLE_HOST   = 2'h1,
        DRRC_ROLE_DEVICE = 2'h2
    } drrc_role_t;
    typedef enum logic [3:0] {
        DRRC_ST_OFF    = 4'h1,
        DRRC_ST_SAMPLE = 4'h2,
        DRRC_ST_WAIT   = 4'h4,
        DRRC_ST_READY  = 4'h8
    } drrc_state_t;
endpackage

// ### drrc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface drrc_if;
    logic active_low_reset_pin;
    logic swap_select;
    logic supplies_good;
    logic host_mode_en0;
    logic periph_mode_en0;
    logic host_mode_en1;
    logic periph_mode_en1;
    modport device (
        input  active_low_reset_pin, swap_select, supplies_good,
        input  host_mode_en0, periph_mode_en0, host_mode_en1, periph_mode_en1
    );
    modport ctrl (
        output active_low_reset_pin, swap_select, supplies_good,
        output host_mode_en0, periph_mode_en0, host_mode_en1, periph_mode_en1
    );
endinterface
`default_nettype wire

// ### drrc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module drrc_ctrl (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  reset_n_i,
    // User requests
    input  wire logic                  reset_req_i,
    input  wire logic                  swap_req_i,
    input  wire logic                  supplies_good_i,
    input  wire drrc_pkg::drrc_role_t  role0_req_i,
    input  wire drrc_pkg::drrc_role_t  role1_req_i,
    // Status
    output logic                       busy_o,
    // Link
    drrc_if.ctrl                       link
);
    import drrc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic               rst_pin;
        logic               swap;
        logic               sup;
        logic               busy;
        logic [CNT_W-1:0]   cnt;
        logic [1:0]         role0;
        logic [1:0]         role1;
    } drrc_ctrl_st_t;
    drrc_ctrl_st_t st_ff;
    drrc_ctrl_st_t nxt_st;
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sup   = supplies_good_i;
        nxt_st.role0 = role0_req_i;
        nxt_st.role1 = role1_req_i;
        if (st_ff.busy) begin
            // Swap select frozen while busy, covering the hold window.
            nxt_st.cnt = st_ff.cnt - 16'h0001;
            if (st_ff.cnt == 16'h0000) begin
                nxt_st.busy = 1'b0;
            end
            // Release after the minimum low pulse; swap already settled.
            if (!st_ff.rst_pin && st_ff.cnt == 16'h0000) begin
                nxt_st.rst_pin = 1'b1;
                nxt_st.busy    = 1'b1;
                nxt_st.cnt     = CNT_W'(SWAP_HOLD_CYC);
            end
        end else begin
            // Free to move once the hold window is over; the device ignores it until reset.
            nxt_st.swap = swap_req_i;
            if (reset_req_i) begin
                nxt_st.rst_pin = 1'b0;
                nxt_st.busy    = 1'b1;
                nxt_st.cnt     = CNT_W'(MIN_RESET_LOW_CYC);
            end
        end
    end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '{rst_pin: 1'b0, swap: 1'b0, sup: 1'b0, busy: 1'b0,
                       cnt: 16'h0000, role0: 2'h0, role1: 2'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign link.active_low_reset_pin = st_ff.rst_pin;
    assign link.swap_select          = st_ff.swap;
    assign link.supplies_good        = st_ff.sup;
    // Each repeater's enables come from its own request.
    assign link.host_mode_en0        = (st_ff.role0 == DRRC_ROLE_HOST);
    assign link.periph_mode_en0      = (st_ff.role0 == DRRC_ROLE_DEVICE);
    assign link.host_mode_en1        = (st_ff.role1 == DRRC_ROLE_HOST);
    assign link.periph_mode_en1      = (st_ff.role1 == DRRC_ROLE_DEVICE);
    assign busy_o                    = st_ff.busy;
endmodule
`default_nettype wire

// ### drrc_dev.sv
`timescale 1ns/1ns
`default_nettype none
module drrc_dev (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  reset_n_i,
    // Link
    drrc_if.device                     link,
    // Status
    output logic                       power_down_o,
    output logic                       ready_o,
    output logic                       swap_latched_o,
    output logic                       port_a_src_o,
    output logic                       port_b_src_o,
    output drrc_pkg::drrc_role_t       role0_o,
    output drrc_pkg::drrc_role_t       role1_o,
    output logic [2:0]                 speeds0_o,
    output logic [2:0]                 speeds1_o
);
    import drrc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0]         rst_sync;
        logic [1:0]         sup_sync;
        logic [1:0]         swap_sync;
        logic [1:0]         h0_sync;
        logic [1:0]         p0_sync;
        logic [1:0]         h1_sync;
        logic [1:0]         p1_sync;
        drrc_state_t        state;
        logic [CNT_W-1:0]   cnt;
        logic               swap;
        logic               pd;
        logic               ready;
        logic               a_src;
        logic               b_src;
        drrc_role_t         role0;
        drrc_role_t         role1;
    } drrc_dev_st_t;
    drrc_dev_st_t st_ff;
    drrc_dev_st_t nxt_st;
    logic         rst_pin;
    logic         sup_ok;
    ////////////////////////////////////////////////////////////////////////////
    // Host enable wins if the SoC ever raises both.
    function automatic drrc_role_t role_of(input logic host_en, input logic periph_en);
        if (host_en) begin
            return DRRC_ROLE_HOST;
        end
        if (periph_en) begin
            return DRRC_ROLE_DEVICE;
        end
        return DRRC_ROLE_NONE;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    assign rst_pin = st_ff.rst_sync[1];
    assign sup_ok  = st_ff.sup_sync[1];
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.rst_sync  = {st_ff.rst_sync[0], link.active_low_reset_pin};
        nxt_st.sup_sync  = {st_ff.sup_sync[0], link.supplies_good};
        nxt_st.swap_sync = {st_ff.swap_sync[0], link.swap_select};
        nxt_st.h0_sync   = {st_ff.h0_sync[0], link.host_mode_en0};
        nxt_st.p0_sync   = {st_ff.p0_sync[0], link.periph_mode_en0};
        nxt_st.h1_sync   = {st_ff.h1_sync[0], link.host_mode_en1};
        nxt_st.p1_sync   = {st_ff.p1_sync[0], link.periph_mode_en1};
        nxt_st.pd        = 1'b0;
        // Mapping follows the latched select only.
        nxt_st.a_src     = st_ff.swap;
        nxt_st.b_src     = ~st_ff.swap;
        if (!rst_pin || !sup_ok) begin
            // Internal reset held while pin low or supplies bad.
            nxt_st.state = DRRC_ST_OFF;
            nxt_st.pd    = ~rst_pin;
            nxt_st.ready = 1'b0;
            nxt_st.role0 = DRRC_ROLE_NONE;
            nxt_st.role1 = DRRC_ROLE_NONE;
            nxt_st.cnt   = CNT_W'(SWAP_SAMPLE_CYC - 1);
        end else begin
            case (st_ff.state)
                DRRC_ST_OFF: begin
                    nxt_st.state = DRRC_ST_SAMPLE;
                end
                DRRC_ST_SAMPLE: begin
                    nxt_st.cnt = st_ff.cnt - 16'h0001;
                    if (st_ff.cnt == 16'h0000) begin
                        // Latched once, 1 ms after internal reset.
                        nxt_st.swap  = st_ff.swap_sync[1];
                        nxt_st.state = DRRC_ST_WAIT;
                        // Two sync stages, the exit from OFF, the WAIT cycle at count zero and one cycle of margin
                        // come off the ready delay, so ready lands just inside 3 ms.
                        nxt_st.cnt   = CNT_W'(READY_DELAY_CYC - SWAP_SAMPLE_CYC - 5);
                    end
                end
                DRRC_ST_WAIT: begin
                    nxt_st.cnt = st_ff.cnt - 16'h0001;
                    if (st_ff.cnt == 16'h0000) begin
                        // Ready inside 3 ms of the later event.
                        nxt_st.state = DRRC_ST_READY;
                        nxt_st.ready = 1'b1;
                    end
                end
                DRRC_ST_READY: begin
                    // Swap select ignored here; roles tracked per repeater.
                    nxt_st.role0 = role_of(st_ff.h0_sync[1], st_ff.p0_sync[1]);
                    nxt_st.role1 = role_of(st_ff.h1_sync[1], st_ff.p1_sync[1]);
                end
                default: begin
                    nxt_st.state = DRRC_ST_OFF;
                end
            endcase
        end
    end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '{rst_sync: 2'h0, sup_sync: 2'h0, swap_sync: 2'h0, h0_sync: 2'h0,
                       p0_sync: 2'h0, h1_sync: 2'h0, p1_sync: 2'h0, state: DRRC_ST_OFF,
                       cnt: 16'h0000, swap: 1'b0, pd: 1'b1, ready: 1'b0, a_src: 1'b0,
                       b_src: 1'b1, role0: DRRC_ROLE_NONE, role1: DRRC_ROLE_NONE};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign power_down_o   = st_ff.pd;
    assign ready_o        = st_ff.ready;
    assign swap_latched_o = st_ff.swap;
    assign port_a_src_o   = st_ff.a_src;
    assign port_b_src_o   = st_ff.b_src;
    assign role0_o        = st_ff.role0;
    assign role1_o        = st_ff.role1;
    // All three speeds enabled on each port once ready: {hs, fs, ls}.
    assign speeds0_o      = {3{st_ff.ready}};
    assign speeds1_o      = {3{st_ff.ready}};
endmodule
`default_nettype wire

// ### drrc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module drrc_checker (
    // Clock, reset and link
    input wire logic                 mclk_i,
    input wire logic                 reset_n_i,
    input wire logic                 active_low_reset_pin,
    input wire logic                 swap_select,
    input wire logic                 supplies_good,
    input wire logic                 host_mode_en0,
    input wire logic                 periph_mode_en0,
    input wire logic                 periph_mode_en1,
    input wire logic                 host_mode_en1,
    // Device status
    input wire logic                 power_down_o,
    input wire logic                 ready_o,
    input wire logic                 swap_latched_o,
    input wire logic                 port_a_src_o,
    input wire logic                 port_b_src_o,
    input wire drrc_pkg::drrc_role_t role0_o,
    input wire drrc_pkg::drrc_role_t role1_o,
    input wire logic [2:0]           speeds0_o,
    input wire logic [2:0]           speeds1_o
);
    import drrc_pkg::*;
    ////////////////////////////////////////////////////////////
    // Counts from the later of pin release and supplies good; saturates so it never wraps.
    logic [15:0] up_ff;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_ff <= 16'h0;
        end else if (!(active_low_reset_pin && supplies_good)) begin
            up_ff <= 16'h0;
        end else if (up_ff != 16'hFFFF) begin
            up_ff <= up_ff + 16'h1;
        end
    end
    // Cycles the reset pin has stood low, and high, without a break; both saturate.
    logic [15:0] low_ff;
    logic [15:0] hi_ff;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_ff <= 16'h0;
            hi_ff  <= 16'h0;
        end else if (active_low_reset_pin) begin
            low_ff <= 16'h0;
            hi_ff  <= (hi_ff != 16'hFFFF) ? hi_ff + 16'h1 : hi_ff;
        end else begin
            low_ff <= (low_ff != 16'hFFFF) ? low_ff + 16'h1 : low_ff;
            hi_ff  <= 16'h0;
        end
    end
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////
    AST_PD: assert property ((!active_low_reset_pin)[*4] |-> power_down_o && !ready_o)
        else $error("not powered down with reset pin low");
    AST_POR: assert property ((!supplies_good)[*4] |-> !ready_o)
        else $error("ready while supplies not good");
    AST_RDY: assert property (!ready_o |-> up_ff < CNT_W'(READY_DELAY_CYC))
        else $error("ready late");
    AST_LATCH: assert property ($changed(swap_latched_o) && supplies_good
        && active_low_reset_pin |-> up_ff >= CNT_W'(SWAP_SAMPLE_CYC)
        && swap_latched_o == swap_select)
        else $error("swap latched early or wrong");
    AST_HOLD: assert property (ready_o && $past(ready_o) |-> $stable(swap_latched_o))
        else $error("mapping changed while running");
    AST_MAP: assert property (ready_o |-> port_a_src_o == swap_latched_o
        && port_b_src_o == !swap_latched_o)
        else $error("port mapping wrong");
    AST_SPD: assert property (ready_o |-> speeds0_o == 3'h7 && speeds1_o == 3'h7)
        else $error("speeds missing");
    AST_HOST: assert property ((ready_o && host_mode_en0)[*4] |-> role0_o == DRRC_ROLE_HOST)
        else $error("repeater zero not host");
    AST_DEV: assert property ((ready_o && periph_mode_en1 && !host_mode_en1)[*4]
        |-> role1_o == DRRC_ROLE_DEVICE)
        else $error("repeater one not device");
    AST_DEV0: assert property ((ready_o && periph_mode_en0 && !host_mode_en0)[*4]
        |-> role0_o == DRRC_ROLE_DEVICE)
        else $error("repeater zero not device");
    AST_LOW: assert property ($rose(active_low_reset_pin)
        |-> low_ff >= CNT_W'(MIN_RESET_LOW_CYC))
        else $error("reset pin low pulse too short");
    AST_SWHOLD: assert property ($changed(swap_select)
        |-> !active_low_reset_pin || hi_ff >= CNT_W'(SWAP_HOLD_CYC))
        else $error("swap select moved inside the hold window");
    AST_CLR: assert property ((!ready_o)[*2] |-> role0_o == DRRC_ROLE_NONE
        && role1_o == DRRC_ROLE_NONE)
        else $error("role kept while not ready");
endmodule
`default_nettype wire

// ### dual_repeater_reset_crossbar_config_test.sv
`timescale 1ns/1ns
`default_nettype none
module dual_repeater_reset_crossbar_config_test;
    import drrc_pkg::*;
    logic       mclk_i, reset_n_i, reset_req_i, swap_req_i, supplies_good_i, busy_o, sw;
    logic       power_down_o, ready_o, swap_latched_o, port_a_src_o, port_b_src_o;
    logic [2:0] speeds0_o, speeds1_o;
    drrc_role_t role0_req_i, role1_req_i, role0_o, role1_o;
    int         n_fail = 0, samples_checked = 0, seed;
    drrc_if link();
    drrc_ctrl drrc_ctrl_i (.mclk_i, .reset_n_i, .reset_req_i, .swap_req_i, .supplies_good_i,
        .role0_req_i, .role1_req_i, .busy_o, .link(link));
    drrc_dev drrc_dev_i (.mclk_i, .reset_n_i, .link(link), .power_down_o, .ready_o,
        .swap_latched_o, .port_a_src_o, .port_b_src_o, .role0_o, .role1_o, .speeds0_o, .speeds1_o);
    drrc_checker drrc_checker_i (.mclk_i, .reset_n_i,
        .active_low_reset_pin(link.active_low_reset_pin), .swap_select(link.swap_select),
        .supplies_good(link.supplies_good), .host_mode_en0(link.host_mode_en0),
        .periph_mode_en0(link.periph_mode_en0),
        .periph_mode_en1(link.periph_mode_en1), .host_mode_en1(link.host_mode_en1),
        .power_down_o, .ready_o, .swap_latched_o, .port_a_src_o, .port_b_src_o, .role0_o,
        .role1_o, .speeds0_o, .speeds1_o);
    ////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    function automatic logic src_of(input logic s, input logic port_b);
        return s ^ port_b;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One device reset with a chosen swap; late delays supplies good past pin release.
    task automatic run(input logic s, input int late);
        drrc_role_t r0, r1;
        int k = 0;
        swap_req_i = s;
        reset_req_i = 1'b1;
        supplies_good_i = (late == 0);
        @(negedge mclk_i);
        reset_req_i = 1'b0;
        repeat (60) @(negedge mclk_i);
        chk("power_down", power_down_o, 1'b1);
        chk("role_clear", role0_o, DRRC_ROLE_NONE);
        repeat (late + 60) @(negedge mclk_i);
        chk("ready_no_supply", ready_o, 1'b0);
        supplies_good_i = 1'b1;
        while (ready_o !== 1'b1 && k < 30010) begin
            @(negedge mclk_i);
            k++;
        end
        if (k >= 30010) begin
            n_fail++;
            finish_test();
        end
        chk("swap_latched", swap_latched_o, s);
        chk("port_a_src", port_a_src_o, src_of(s, 1'b0));
        chk("port_b_src", port_b_src_o, src_of(s, 1'b1));
        chk("speeds", {2'h0, speeds0_o, speeds1_o}, 8'h3F);
        // Every pairing of the three role codes, so each repeater is shown to be independent.
        for (int i = 0; i < 9; i++) begin
            r0 = drrc_role_t'(i % 3);
            r1 = drrc_role_t'(i / 3);
            role0_req_i = r0;
            role1_req_i = r1;
            repeat (6) @(negedge mclk_i);
            chk("role0", role0_o, r0);
            chk("role1", role1_o, r1);
        end
    endtask
    initial begin
        reset_n_i = 1'b0;
        reset_req_i = 1'b0;
        swap_req_i = 1'b0;
        supplies_good_i = 1'b0;
        role0_req_i = DRRC_ROLE_NONE;
        role1_req_i = DRRC_ROLE_NONE;
        seed = $urandom(19881);
        repeat (5) @(negedge mclk_i);
        reset_n_i = 1'b1;
        @(negedge mclk_i);
        sw = 1'($urandom);
        run(sw, 0);
        repeat (300) @(negedge mclk_i);
        chk("busy", busy_o, 1'b0);
        // Move the select while running; the latched mapping must not follow it.
        swap_req_i = !sw;
        repeat (10) @(negedge mclk_i);
        chk("swap_ignored", swap_latched_o, sw);
        chk("port_a_kept", port_a_src_o, src_of(sw, 1'b0));
        run(!sw, 100 + int'($urandom_range(1900)));
        finish_test();
    end
endmodule
`default_nettype wire
